// file: hw/link_param_pkg.sv
// Purpose: Constants and types for the link parameter register bank.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes:   Printed offsets are not all multiples of four, so they are indices.
// How it works
// - Scrambler bit enables or bypasses scrambling
// - Lane field zero means one lane
// - Octets per frame reads 2M over L
// - Converter field zero means one converter
// - Control bits field selects none, one, two
// - Resolution field reads thirteen
// - Subclass field selects class zero or one
// - Sample width field reads fifteen
// - Samples field reads zero, bit five kept
// - High density bit reads zero
// - Control words field reads zero
// - Two free scratch registers
// - Checksum is parameter sum modulo 256
// - Driver power-down bit disables drivers
// - SYSREF loads multiframe phase offset
// - Emphasis codes 0x04 off, 0x14 on
// - Programmable eight-bit device identifier
// - Programmable four-bit bank identifier
// - Programmable five-bit lane identifier
package link_param_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DEVICE_IDENT  = 8'h64;
  localparam logic [7:0] IDX_BANK_IDENT    = 8'h65;
  localparam logic [7:0] IDX_LANE_IDENT    = 8'h67;
  localparam logic [7:0] IDX_SCRAMBLE_LANE = 8'h6E;
  localparam logic [7:0] IDX_OCTETS_FRAME  = 8'h6F;
  localparam logic [7:0] IDX_FRAMES_MULTI  = 8'h70;
  localparam logic [7:0] IDX_CONV_COUNT    = 8'h71;
  localparam logic [7:0] IDX_CTRL_RES      = 8'h72;
  localparam logic [7:0] IDX_SUBCLASS_WID  = 8'h73;
  localparam logic [7:0] IDX_SAMPLES_FRAME = 8'h74;
  localparam logic [7:0] IDX_DENSITY_CW    = 8'h75;
  localparam logic [7:0] IDX_SCRATCH_A     = 8'h76;
  localparam logic [7:0] IDX_SCRATCH_B     = 8'h77;
  localparam logic [7:0] IDX_CONFIG_SUM    = 8'h79;
  localparam logic [7:0] IDX_DRIVER_CTRL   = 8'h80;
  localparam logic [7:0] IDX_PHASE_OFFSET  = 8'h8B;
  localparam logic [7:0] IDX_EMPHASIS      = 8'hA8;
  localparam int         ADDR_W            = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCR_BIT       = 7;
  localparam int CS_LSB        = 6;
  localparam int SUBCLASS_LSB  = 5;
  localparam int S_RSV_BIT     = 5;
  localparam int HD_BIT        = 7;
  localparam int DRV_PD_BIT    = 1;

  // ----------------------------------------------------------------
  // Fixed readback values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] RESOLUTION_M1  = 4'hD;
  localparam logic [3:0] SAMPLE_BITS_M1 = 4'hF;
  localparam logic [4:0] SAMPLES_M1     = 5'h00;
  localparam logic [4:0] CTRL_WORDS     = 5'h00;
  localparam logic [7:0] EMPH_OFF       = 8'h04;
  localparam logic [7:0] EMPH_ON        = 8'h14;
  localparam logic [1:0] CS_NONE        = 2'h0;
  localparam logic [1:0] CS_ONE         = 2'h1;
  localparam logic [1:0] CS_TWO         = 2'h2;
  localparam logic [1:0] SUBCLASS_ZERO  = 2'h0;
  localparam logic [1:0] SUBCLASS_ONE   = 2'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DEVICE_IDENT = 8'h00;
  localparam logic [3:0] RST_BANK_IDENT   = 4'h0;
  localparam logic [4:0] RST_LANE_IDENT   = 5'h00;
  localparam logic       RST_SCR          = 1'b0;
  localparam logic [4:0] RST_LANES_M1     = 5'h00;
  localparam logic [7:0] RST_FRAMES_MULTI = 8'h1F;
  localparam logic [7:0] RST_CONV_M1      = 8'h00;
  localparam logic [1:0] RST_CS           = 2'h0;
  localparam logic [1:0] RST_SUBCLASS     = 2'h1;
  localparam logic       RST_S_RSV        = 1'b1;
  localparam logic [7:0] RST_SCRATCH      = 8'h00;
  localparam logic       RST_DRV_PD       = 1'b0;
  localparam logic [4:0] RST_PHASE_OFFSET = 5'h00;
  localparam logic [7:0] RST_EMPHASIS     = 8'h04;
  localparam logic [4:0] PHASE_ZERO       = 5'h00;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       scramble_en;
    logic [4:0] lanes_m1;
    logic [7:0] octets_per_frame;
    logic [7:0] frames_per_multi;
    logic [7:0] converters_m1;
    logic [1:0] ctrl_bits;
    logic [1:0] subclass;
    logic [7:0] device_ident;
    logic [3:0] bank_ident;
    logic [4:0] lane_ident;
    logic [7:0] config_sum;
  } link_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : link_param_pkg

// file: hw/link_param_regs.sv
// Purpose: APB register bank holding the serial link parameters.
// Assumes: Single clock, synchronous active-low reset, zero wait-state APB.
// Notes:   Read-only fields are computed, never stored.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module link_param_regs
  import link_param_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // APB slave
  input  wire apb_req_t          apb_req_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Link timing
  input  wire logic              sysref_i,
  input  wire logic              frame_tick_i,
  // Link controls
  output link_cfg_t              link_cfg_o,
  output logic                   drivers_pd_o,
  output logic                   emphasis_en_o,
  output logic [4:0]             mf_phase_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] device_ident;
  logic [3:0] bank_ident;
  logic [4:0] lane_ident;
  logic       scramble_en;
  logic [4:0] lanes_m1;
  logic [7:0] frames_multi;
  logic [7:0] conv_m1;
  logic [1:0] ctrl_bits;
  logic [1:0] subclass;
  logic       s_reserved;
  logic [7:0] scratch_a;
  logic [7:0] scratch_b;
  logic       drv_pd;
  logic [4:0] phase_offset;
  logic [7:0] emphasis;
  logic [4:0] mf_phase;
  logic       sysref_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        access   = apb_req_i.psel & apb_req_i.penable;
  wire        wr_en    = access & apb_req_i.pwrite;
  wire        word_ok  = (apb_req_i.paddr[1:0] == 2'h0);
  wire  [7:0] idx      = apb_req_i.paddr[ADDR_W-1:2];
  wire        hit_did  = word_ok && (idx == IDX_DEVICE_IDENT);
  wire        hit_bid  = word_ok && (idx == IDX_BANK_IDENT);
  wire        hit_lid  = word_ok && (idx == IDX_LANE_IDENT);
  wire        hit_scl  = word_ok && (idx == IDX_SCRAMBLE_LANE);
  wire        hit_f    = word_ok && (idx == IDX_OCTETS_FRAME);
  wire        hit_k    = word_ok && (idx == IDX_FRAMES_MULTI);
  wire        hit_m    = word_ok && (idx == IDX_CONV_COUNT);
  wire        hit_ncs  = word_ok && (idx == IDX_CTRL_RES);
  wire        hit_sub  = word_ok && (idx == IDX_SUBCLASS_WID);
  wire        hit_s    = word_ok && (idx == IDX_SAMPLES_FRAME);
  wire        hit_hd   = word_ok && (idx == IDX_DENSITY_CW);
  wire        hit_sa   = word_ok && (idx == IDX_SCRATCH_A);
  wire        hit_sb   = word_ok && (idx == IDX_SCRATCH_B);
  wire        hit_sum  = word_ok && (idx == IDX_CONFIG_SUM);
  wire        hit_drv  = word_ok && (idx == IDX_DRIVER_CTRL);
  wire        hit_ph   = word_ok && (idx == IDX_PHASE_OFFSET);
  wire        hit_emp  = word_ok && (idx == IDX_EMPHASIS);
  wire        mapped   = hit_did | hit_bid | hit_lid | hit_scl | hit_f | hit_k | hit_m
                       | hit_ncs | hit_sub | hit_s | hit_hd | hit_sa | hit_sb
                       | hit_sum | hit_drv | hit_ph | hit_emp;
  wire  [7:0] wd       = apb_req_i.pwdata[7:0];
  // Read data is captured in the setup cycle of a read only
  wire        rd_setup = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;

  // ----------------------------------------------------------------
  // Derived parameters
  // ----------------------------------------------------------------
  // lane count code
  wire  [8:0] lanes    = {4'h0, lanes_m1} + 9'h001;
  wire  [8:0] convs    = {1'b0, conv_m1} + 9'h001;
  wire  [9:0] f_num    = {convs, 1'b0};
  wire  [9:0] f_val    = f_num / {1'b0, lanes};
  wire  [7:0] octets   = f_val[7:0];

  wire  [7:0] cfg_sum  = device_ident + {4'h0, bank_ident} + {3'h0, lane_ident}
                       + {7'h00, scramble_en} + {3'h0, lanes_m1} + (octets - 8'h01)
                       + (frames_multi - 8'h01) + conv_m1 + {6'h00, ctrl_bits}
                       + {4'h0, RESOLUTION_M1} + {6'h00, subclass}
                       + {4'h0, SAMPLE_BITS_M1} + {3'h0, SAMPLES_M1}
                       + {3'h0, CTRL_WORDS};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // fixed resolution readback
  wire  [7:0] rd_ncs   = {ctrl_bits, 2'h0, RESOLUTION_M1};
  wire  [7:0] rd_sub   = {1'b0, subclass, 1'b0, SAMPLE_BITS_M1};
  wire  [7:0] rd_s     = {2'h0, s_reserved, SAMPLES_M1};
  wire  [7:0] rd_hd    = {1'b0, 2'h0, CTRL_WORDS};
  wire  [7:0] rd_byte  = hit_did ? device_ident
                       : hit_bid ? {4'h0, bank_ident}
                       : hit_lid ? {3'h0, lane_ident}
                       : hit_scl ? {scramble_en, 2'h0, lanes_m1}
                       : hit_f   ? octets
                       : hit_k   ? frames_multi
                       : hit_m   ? conv_m1
                       : hit_ncs ? rd_ncs
                       : hit_sub ? rd_sub
                       : hit_s   ? rd_s
                       : hit_hd  ? rd_hd
                       : hit_sa  ? scratch_a
                       : hit_sb  ? scratch_b
                       : hit_sum ? cfg_sum
                       : hit_drv ? {6'h00, drv_pd, 1'b0}
                       : hit_ph  ? {3'h0, phase_offset}
                       : hit_emp ? emphasis
                       : 8'h00;

  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      prdata_o <= RDATA_ZERO;
    end else if (rd_setup) begin
      prdata_o <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      device_ident <= RST_DEVICE_IDENT;
      bank_ident   <= RST_BANK_IDENT;
      lane_ident   <= RST_LANE_IDENT;
      scramble_en  <= RST_SCR;
      lanes_m1     <= RST_LANES_M1;
      frames_multi <= RST_FRAMES_MULTI;
      conv_m1      <= RST_CONV_M1;
      ctrl_bits    <= RST_CS;
      subclass     <= RST_SUBCLASS;
      s_reserved   <= RST_S_RSV;
      scratch_a    <= RST_SCRATCH;
      scratch_b    <= RST_SCRATCH;
      drv_pd       <= RST_DRV_PD;
      phase_offset <= RST_PHASE_OFFSET;
      emphasis     <= RST_EMPHASIS;
    end else if (wr_en) begin
      if (hit_did) device_ident <= wd;
      if (hit_bid) bank_ident <= wd[3:0];
      if (hit_lid) lane_ident <= wd[4:0];
      if (hit_scl) scramble_en <= wd[SCR_BIT];
      if (hit_scl) lanes_m1 <= wd[4:0];
      if (hit_k) frames_multi <= wd;
      if (hit_m) conv_m1 <= wd;
      if (hit_ncs) ctrl_bits <= wd[CS_LSB +: 2];
      if (hit_sub) subclass <= wd[SUBCLASS_LSB +: 2];
      if (hit_s) s_reserved <= wd[S_RSV_BIT];
      if (hit_sa) scratch_a <= wd;
      if (hit_sb) scratch_b <= wd;
      if (hit_drv) drv_pd <= wd[DRV_PD_BIT];
      if (hit_ph) phase_offset <= wd[4:0];
      if (hit_emp) emphasis <= wd;
    end
  end

  // ----------------------------------------------------------------
  // Multiframe phase counter
  // ----------------------------------------------------------------
  // Phase wraps at the programmed frames per multiframe; a zero
  // multiframe length would never wrap, so the low bits are used.
  wire        sysref_rise = sysref_i & ~sysref_q;
  wire  [4:0] mf_last     = frames_multi[4:0] - 5'h01;
  wire  [4:0] next_phase  = (mf_phase == mf_last) ? PHASE_ZERO : mf_phase + 5'h01;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sysref_q <= 1'b0;
      mf_phase <= PHASE_ZERO;
    end else begin
      sysref_q <= sysref_i;
      if (sysref_rise) begin
        mf_phase <= phase_offset;
      end else if (frame_tick_i) begin
        mf_phase <= next_phase;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      link_cfg_o    <= '0;
      drivers_pd_o  <= 1'b0;
      emphasis_en_o <= 1'b0;
    end else begin
      link_cfg_o.scramble_en      <= scramble_en;
      link_cfg_o.lanes_m1         <= lanes_m1;
      link_cfg_o.octets_per_frame <= octets;
      link_cfg_o.frames_per_multi <= frames_multi;
      link_cfg_o.converters_m1    <= conv_m1;
      link_cfg_o.ctrl_bits        <= ctrl_bits;
      link_cfg_o.subclass         <= subclass;
      link_cfg_o.device_ident     <= device_ident;
      link_cfg_o.bank_ident       <= bank_ident;
      link_cfg_o.lane_ident       <= lane_ident;
      link_cfg_o.config_sum       <= cfg_sum;
      drivers_pd_o                <= drv_pd;
      // Any code other than the enable code leaves emphasis off
      emphasis_en_o               <= (emphasis == EMPH_ON);
    end
  end

  assign mf_phase_o = mf_phase;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  scr_follows_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_en && hit_scl |=> ##1 link_cfg_o.scramble_en == $past(wd[SCR_BIT], 2))
    else $error("scrambler enable did not follow write");

  f_readback_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (lanes_m1 == 5'h00 && conv_m1 == 8'h00) |-> octets == 8'h02)
    else $error("octets per frame not two");

  res_ro_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_setup && hit_ncs |=> prdata_o[3:0] == 4'hD)
    else $error("resolution readback wrong");

  width_ro_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_setup && hit_sub |=> prdata_o[3:0] == 4'hF)
    else $error("sample width readback wrong");

  density_zero_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_setup && hit_hd |=> prdata_o[7:0] == 8'h00)
    else $error("density word not zero");

  scratch_keep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_en && hit_sa |=> scratch_a == $past(wd))
    else $error("scratch write lost");

  sum_tracks_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_en && hit_did |=> ##1 link_cfg_o.config_sum == $past(cfg_sum))
    else $error("checksum not updated");

  drv_pd_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_en && hit_drv |=> ##1 drivers_pd_o == $past(wd[DRV_PD_BIT], 2))
    else $error("driver power-down mismatch");

  phase_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    sysref_i && !sysref_q |=> mf_phase == $past(phase_offset))
    else $error("phase offset not loaded");

  emph_code_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_en && hit_emp && wd == 8'h14 |=> ##1 emphasis_en_o)
    else $error("emphasis not enabled");

endmodule : link_param_regs

// file: testbench/link_timing_src.sv
// Purpose: Far-side timing source that drives the alignment and frame inputs.
// Assumes: Signals change only by non-blocking assignment after a rising edge.
// Notes:   The alignment strobe is held for two cycles so edge detection sees it.
`timescale 1ns/1ns
module link_timing_src (
  // Clock
  input  wire logic ref_clk_i,
  // Timing outputs
  output logic      sysref_o,
  output logic      frame_tick_o
);
  initial begin
    sysref_o     = 1'b0;
    frame_tick_o = 1'b0;
  end

  task automatic sysref_pulse();
    @(posedge ref_clk_i);
    sysref_o <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sysref_o <= 1'b0;
  endtask : sysref_pulse

  // Single frame tick, one cycle wide
  task automatic frame_tick();
    @(posedge ref_clk_i);
    frame_tick_o <= 1'b1;
    @(posedge ref_clk_i);
    frame_tick_o <= 1'b0;
  endtask : frame_tick
endmodule : link_timing_src

// file: testbench/jesd204b_link_param_regs_test.sv
// Purpose: Self-checking bench for the link parameter register bank.
// Assumes: Zero wait-state APB slave; byte address is four times the index.
// Notes:   Table rows cover reset values and read-back; odd cases follow by hand.
`timescale 1ns/1ns
module jesd204b_link_param_regs_test;
  import link_param_pkg::*;

  typedef struct packed {
    logic [7:0] idx;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] ex;
    logic       er;
  } row_t;

  logic        ref_clk_i;
  logic        nrst_i;
  apb_req_t    apb_req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref;
  logic        frame_tick;
  link_cfg_t   link_cfg;
  logic        drivers_pd;
  logic        emphasis_en;
  logic [4:0]  mf_phase;
  int          n_errors;
  int          check_count;
  logic [31:0] rd;
  logic        er;

  link_param_regs link_param_regs_i (
    .ref_clk_i    (ref_clk_i),
    .nrst_i       (nrst_i),
    .apb_req_i    (apb_req),
    .prdata_o     (prdata),
    .pready_o     (pready),
    .pslverr_o    (pslverr),
    .sysref_i     (sysref),
    .frame_tick_i (frame_tick),
    .link_cfg_o   (link_cfg),
    .drivers_pd_o (drivers_pd),
    .emphasis_en_o(emphasis_en),
    .mf_phase_o   (mf_phase)
  );

  link_timing_src link_timing_src_i (
    .ref_clk_i   (ref_clk_i),
    .sysref_o    (sysref),
    .frame_tick_o(frame_tick)
  );

  always #20 ref_clk_i = ~ref_clk_i;

  // --------------------------------------------------------------
  // Reporting
  // --------------------------------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  // --------------------------------------------------------------
  // APB master: hold the request until pready is seen high
  // --------------------------------------------------------------
  task automatic apb(input logic [9:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] data, output logic err);
    int n;
    @(posedge ref_clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
    @(posedge ref_clk_i);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end else begin
      data = prdata;
      err  = pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
    end
  endtask : apb

  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

  // Reset reads, then writes with read-back; driver power-down comes first
  row_t rows [] = '{
    '{8'h64,1'b0,8'h00,8'h00,1'b0}, '{8'h65,1'b0,8'h00,8'h00,1'b0}, '{8'h67,1'b0,8'h00,8'h00,1'b0},
    '{8'h6E,1'b0,8'h00,8'h00,1'b0}, '{8'h6F,1'b0,8'h00,8'h02,1'b0}, '{8'h70,1'b0,8'h00,8'h1F,1'b0},
    '{8'h71,1'b0,8'h00,8'h00,1'b0}, '{8'h72,1'b0,8'h00,8'h0D,1'b0}, '{8'h73,1'b0,8'h00,8'h2F,1'b0},
    '{8'h74,1'b0,8'h00,8'h20,1'b0}, '{8'h75,1'b0,8'h00,8'h00,1'b0}, '{8'h76,1'b0,8'h00,8'h00,1'b0},
    '{8'h77,1'b0,8'h00,8'h00,1'b0}, '{8'h79,1'b0,8'h00,8'h3C,1'b0}, '{8'h80,1'b0,8'h00,8'h00,1'b0},
    '{8'h8B,1'b0,8'h00,8'h00,1'b0}, '{8'hA8,1'b0,8'h00,8'h04,1'b0}, '{8'h66,1'b0,8'h00,8'h00,1'b1},
    '{8'h80,1'b1,8'h02,8'h02,1'b0}, '{8'h64,1'b1,8'hA5,8'hA5,1'b0}, '{8'h65,1'b1,8'hFF,8'h0F,1'b0},
    '{8'h67,1'b1,8'hFF,8'h1F,1'b0}, '{8'h6E,1'b1,8'h80,8'h80,1'b0}, '{8'h6F,1'b1,8'h55,8'h02,1'b0},
    '{8'h70,1'b1,8'h20,8'h20,1'b0}, '{8'h72,1'b1,8'h80,8'h8D,1'b0}, '{8'h73,1'b1,8'h00,8'h0F,1'b0},
    '{8'h75,1'b1,8'hFF,8'h00,1'b0}, '{8'h76,1'b1,8'h5A,8'h5A,1'b0}, '{8'h77,1'b1,8'hC3,8'hC3,1'b0},
    '{8'h79,1'b1,8'hFF,8'h12,1'b0}, '{8'h8B,1'b1,8'h0B,8'h0B,1'b0}, '{8'hA8,1'b1,8'h14,8'h14,1'b0},
    '{8'h66,1'b1,8'h77,8'h00,1'b1}
  };

  initial begin
    ref_clk_i   = 1'b0;
    nrst_i      = 1'b0;
    apb_req     = '0;
    n_errors    = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    // multiframe length written as 0x20; drivers down first
    foreach (rows[i]) begin
      apb(byte_addr(rows[i].idx), rows[i].wr, rows[i].wd, rd, er);
      check("slave error", {31'h0, rows[i].er}, {31'h0, er});
      // Writes carry no read data, so every write row is read back
      if (rows[i].wr === 1'b1) apb(byte_addr(rows[i].idx), 1'b0, 8'h00, rd, er);
      check("read data", {24'h0, rows[i].ex}, rd);
    end
    repeat (2) @(posedge ref_clk_i);
    check("scramble", 32'h1, {31'h0, link_cfg.scramble_en});
    check("lanes", 32'h0, {27'h0, link_cfg.lanes_m1});
    check("converters", 32'h0, {24'h0, link_cfg.converters_m1});
    check("octets", 32'h2, {24'h0, link_cfg.octets_per_frame});
    check("cfg sum", 32'h12, {24'h0, link_cfg.config_sum});
    check("device id", 32'hA5, {24'h0, link_cfg.device_ident});
    check("bank id", 32'h0F, {28'h0, link_cfg.bank_ident});
    check("lane id", 32'h1F, {27'h0, link_cfg.lane_ident});
    check("frames multi", 32'h20, {24'h0, link_cfg.frames_per_multi});
    check("driver pd", 32'h1, {31'h0, drivers_pd});
    check("emphasis", 32'h1, {31'h0, emphasis_en});
    for (int c = 0; c < 3; c++) begin
      apb(byte_addr(IDX_CTRL_RES), 1'b1, {c[1:0], 6'h00}, rd, er);
      repeat (2) @(posedge ref_clk_i);
      check("ctrl bits", c, {30'h0, link_cfg.ctrl_bits});
    end
    for (int s = 0; s < 2; s++) begin
      apb(byte_addr(IDX_SUBCLASS_WID), 1'b1, {1'b0, s[1:0], 5'h00}, rd, er);
      repeat (2) @(posedge ref_clk_i);
      check("subclass", s, {30'h0, link_cfg.subclass});
    end
    apb(byte_addr(IDX_EMPHASIS), 1'b1, 8'h04, rd, er);
    apb(byte_addr(IDX_DRIVER_CTRL), 1'b1, 8'h00, rd, er);
    repeat (2) @(posedge ref_clk_i);
    check("emphasis off", 32'h0, {31'h0, emphasis_en});
    check("driver on", 32'h0, {31'h0, drivers_pd});
    // register bus stays idle while the phase counter runs
    link_timing_src_i.sysref_pulse();
    repeat (3) @(posedge ref_clk_i);
    check("phase load", 32'h0B, {27'h0, mf_phase});
    link_timing_src_i.frame_tick();
    repeat (2) @(posedge ref_clk_i);
    check("phase step", 32'h0C, {27'h0, mf_phase});
    // Unaligned access is refused
    apb(byte_addr(IDX_SCRATCH_A) + 10'h001, 1'b0, 8'h00, rd, er);
    check("unaligned err", 32'h1, {31'h0, er});
    check("unaligned data", 32'h0, rd);
    // Mid-run reset restores defaults
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    apb(byte_addr(IDX_FRAMES_MULTI), 1'b0, 8'h00, rd, er);
    check("reset K", 32'h1F, rd);
    apb(byte_addr(IDX_DEVICE_IDENT), 1'b0, 8'h00, rd, er);
    check("reset id", 32'h0, rd);
    finish_test();
  end
endmodule : jesd204b_link_param_regs_test
